// ==== hdl/dvsrc_ramp_control.v ====
// ramp-rate and linear regulator setpoint control
`timescale 1ns/100ps
`default_nettype none
`include "dvsrc_defines.vh"
module dvsrc_ramp_control #(
  parameter W          = 6,
  parameter BLANK_CYC  = `DVSRC_BLANK_CYC,
  parameter DWELL_CYC  = `DVSRC_DWELL_MIN_CYC
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         reg_wr,
  input  wire         reg_rd,
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         unlocked,
  input  wire         buck_a_set_wr,
  input  wire [W-1:0] buck_a_set,
  input  wire         buck_b_set_wr,
  input  wire [W-1:0] buck_b_set,
  output reg  [7:0]   reg_rdata,
  output reg  [W-1:0] core_buck_a_code,
  output reg  [W-1:0] core_buck_b_code,
  output reg          ramp_busy,
  output reg  [5:0]   linear_reg_code,
  output reg          monitor_blank
);
  reg          trig;
  reg          auto_apply_select;
  reg  [2:0]   rate;
  reg  [W-1:0] set_a;
  reg  [W-1:0] set_b;
  reg  [23:0]  dwell_cnt;
  reg  [31:0]  blank_cnt;
  reg          load;
  reg  [W-1:0] tgt_a;
  reg  [W-1:0] tgt_b;
  wire [W-1:0] a_code;
  wire [W-1:0] b_code;
  wire         a_busy;
  wire         b_busy;
  wire         step_en;
  wire         wr_ramp;
  wire         wr_ldo;
  wire         rd_ramp;
  wire         rd_ldo;
  wire         rate_imm;

  // dwell cycles for a rate code, 2.5 us at code 6, doubling for each code below 6
  function [23:0] dwell_of;
    input [2:0] code;
    begin
      dwell_of = DWELL_CYC[23:0] << (3'h6 - code);
    end
  endfunction

  // register offset match
  function hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  assign wr_ramp = reg_wr && hit(reg_addr, `DVSRC_ADDR_RAMP);
  assign wr_ldo  = reg_wr && hit(reg_addr, `DVSRC_ADDR_LDO);
  assign rd_ramp = reg_rd && hit(reg_addr, `DVSRC_ADDR_RAMP);
  assign rd_ldo  = reg_rd && hit(reg_addr, `DVSRC_ADDR_LDO);
  assign rate_imm = (rate == `DVSRC_RATE_IMMEDIATE);
  assign step_en = (dwell_cnt == 24'h000000);

  // register writes, setpoints and trigger
  always @(posedge clk) begin
    if (!reset_n) begin
      trig              <= 1'b0;
      auto_apply_select <= 1'b0;
      rate              <= `DVSRC_RATE_RESET;
      set_a             <= {W{1'b0}};
      set_b             <= {W{1'b0}};
      load              <= 1'b0;
      tgt_a             <= {W{1'b0}};
      tgt_b             <= {W{1'b0}};
    end else begin
      load <= 1'b0;
      if (buck_a_set_wr) begin
        set_a <= buck_a_set;
      end
      if (buck_b_set_wr) begin
        set_b <= buck_b_set;
      end
      if (auto_apply_select && (buck_a_set_wr || buck_b_set_wr)) begin
        load <= 1'b1;
      end
      if (auto_apply_select && buck_a_set_wr) begin
        tgt_a <= buck_a_set;
      end
      if (auto_apply_select && buck_b_set_wr) begin
        tgt_b <= buck_b_set;
      end
      if (trig && !load && !a_busy && !b_busy) begin
        trig <= 1'b0;
      end
      if (wr_ramp) begin
        auto_apply_select <= reg_wdata[`DVSRC_RAMP_AUTO_BIT];
        rate <= reg_wdata[`DVSRC_RAMP_RATE_MSB:0];
        if (reg_wdata[`DVSRC_RAMP_TRIG_BIT]) begin
          trig  <= 1'b1;
          load  <= 1'b1;
          tgt_a <= buck_a_set_wr ? buck_a_set : set_a;
          tgt_b <= buck_b_set_wr ? buck_b_set : set_b;
        end
      end
    end
  end

  // dwell counter, reloaded on step or load
  always @(posedge clk) begin
    if (!reset_n || load || step_en) begin
      dwell_cnt <= dwell_of(rate) - 24'h000001;
    end else begin
      dwell_cnt <= dwell_cnt - 24'h000001;
    end
  end

  // both steppers share one dwell tick
  // rate drives only core bucks
  dvsrc_stepper #(.W(W)) u_buck_a (
    .clk       (clk),
    .reset_n   (reset_n),
    .init_code ({W{1'b0}}),
    .load      (load),
    .target    (tgt_a),
    .step_en   (step_en),
    .immediate (rate_imm),
    .out_code  (a_code),
    .busy      (a_busy)
  );
  dvsrc_stepper #(.W(W)) u_buck_b (
    .clk       (clk),
    .reset_n   (reset_n),
    .init_code ({W{1'b0}}),
    .load      (load),
    .target    (tgt_b),
    .step_en   (step_en),
    .immediate (rate_imm),
    .out_code  (b_code),
    .busy      (b_busy)
  );

  // output copies of the stepper codes
  always @(posedge clk) begin
    if (!reset_n) begin
      core_buck_a_code <= {W{1'b0}};
      core_buck_b_code <= {W{1'b0}};
      ramp_busy        <= 1'b0;
    end else begin
      core_buck_a_code <= a_code;
      core_buck_b_code <= b_code;
      ramp_busy        <= a_busy | b_busy | load;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      linear_reg_code <= `DVSRC_LDO_RESET;
    end else if (wr_ldo && unlocked) begin
      linear_reg_code <= reg_wdata[`DVSRC_LDO_CODE_MSB:0];
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      blank_cnt     <= 32'h00000000;
      monitor_blank <= 1'b0;
    end else if (wr_ldo) begin
      blank_cnt     <= BLANK_CYC;
      monitor_blank <= 1'b1;
    end else if (blank_cnt != 32'h00000000) begin
      blank_cnt     <= blank_cnt - 32'h00000001;
      monitor_blank <= (blank_cnt != 32'h00000001);
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_ramp) begin
      reg_rdata <= {trig, auto_apply_select, 3'h0, rate};
    end else if (rd_ldo) begin
      reg_rdata <= {2'h0, linear_reg_code};
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/dvsrc_defines.vh ====
// register offsets, fields, reset values and timing counts
`ifndef DVSRC_DEFINES_VH
`define DVSRC_DEFINES_VH
`define DVSRC_ADDR_RAMP        8'h1A
`define DVSRC_ADDR_LDO         8'h1B
`define DVSRC_RAMP_TRIG_BIT    7
`define DVSRC_RAMP_AUTO_BIT    6
`define DVSRC_RAMP_RATE_MSB    2
`define DVSRC_LDO_CODE_MSB     5
`define DVSRC_RATE_RESET       3'h6
`define DVSRC_RATE_IMMEDIATE   3'h7
`define DVSRC_LDO_RESET        6'h33
`define DVSRC_CLK_MHZ          250
`define DVSRC_DWELL_MIN_NS     2500
`define DVSRC_DWELL_MIN_CYC    ((`DVSRC_DWELL_MIN_NS * `DVSRC_CLK_MHZ) / 1000)
`define DVSRC_BLANK_MS         5
`define DVSRC_BLANK_CYC        (`DVSRC_BLANK_MS * `DVSRC_CLK_MHZ * 1000)
`endif

// ==== hdl/dvsrc_stepper.v ====
// one core buck setpoint stepper toward its target code
`timescale 1ns/100ps
`default_nettype none
module dvsrc_stepper #(
  parameter W = 6
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] init_code,
  input  wire         load,
  input  wire [W-1:0] target,
  input  wire         step_en,
  input  wire         immediate,
  output reg  [W-1:0] out_code,
  output reg          busy
);
  reg [W-1:0] goal;
  always @(posedge clk) begin
    if (!reset_n) begin
      goal     <= {W{1'b0}};
      out_code <= {W{1'b0}};
      busy     <= 1'b0;
    end else if (load) begin
      goal <= target;
      busy <= (target != out_code);
    end else if (busy) begin
      if (immediate || out_code == goal) begin
        out_code <= goal;
        busy     <= 1'b0;
      end else if (step_en) begin
        if (out_code < goal) begin
          out_code <= out_code + {{(W-1){1'b0}}, 1'b1};
        end else begin
          out_code <= out_code - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end else if (out_code == {W{1'b0}} && goal == {W{1'b0}}) begin
      out_code <= init_code;
      goal     <= init_code;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/dvsrc_monitor.sv ====
// assertion checker for the ramp and linear setpoint block
`timescale 1ns/100ps
`default_nettype none
module dvsrc_monitor (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       unlocked,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] linear_reg_code,
  input wire logic       monitor_blank,
  input wire logic       ramp_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire lw = reg_wr && reg_addr == 8'h1B;
  a_ldo_rsvd_zero: assert property (reg_rd && reg_addr == 8'h1B
    |=> reg_rdata[7:6] == 2'h0) else $error("linear reserved bits set");
  a_ramp_rsvd_zero: assert property (reg_rd && reg_addr == 8'h1A
    |=> reg_rdata[5:3] == 3'h0) else $error("ramp reserved bits set");
  a_blank_after_write: assert property (lw
    |=> monitor_blank [*8]) else $error("blanking missing");
  a_blank_min_len: assert property ($fell(monitor_blank)
    |-> $past(monitor_blank, 8)) else $error("blanking too short");
  a_locked_no_store: assert property (lw && !unlocked
    |=> $stable(linear_reg_code)) else $error("locked write stored");
  a_linear_store: assert property (lw && unlocked
    |=> linear_reg_code == $past(reg_wdata[5:0]))
    else $error("linear code not stored");
  a_rdata_hold: assert property (!reg_rd
    |=> $stable(reg_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h1A
    && reg_addr != 8'h1B |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_trig_starts_ramp: assert property (reg_wr && reg_addr == 8'h1A
    && reg_wdata[7] |-> ##2 ramp_busy) else $error("trigger no ramp");
  a_ramp_keeps_linear: assert property (reg_wr && reg_addr == 8'h1A
    |=> $stable(linear_reg_code)) else $error("ramp write moved linear");
  c_locked: cover property (lw && !unlocked);
  c_unlocked: cover property (lw && unlocked);
  c_ramp: cover property ($fell(ramp_busy));
endmodule
bind dvsrc_ramp_control dvsrc_monitor u_mon (
  .clk             (clk),
  .reset_n         (reset_n),
  .reg_wr          (reg_wr),
  .reg_rd          (reg_rd),
  .reg_addr        (reg_addr),
  .reg_wdata       (reg_wdata),
  .unlocked        (unlocked),
  .reg_rdata       (reg_rdata),
  .linear_reg_code (linear_reg_code),
  .monitor_blank   (monitor_blank),
  .ramp_busy       (ramp_busy)
);
`default_nettype wire

// ==== testbench/dvsrc_host.sv ====
// host side register access model
`timescale 1ns/100ps
`default_nettype none
module dvsrc_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk) {reg_rd, reg_addr} = {1'b0, ~a};
    @(negedge clk) d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the ramp and linear setpoint block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic            clk = 1'b0, reset_n = 1'b0, unlocked = 1'b0;
  logic            a_wr = 1'b0, b_wr = 1'b0;
  logic            light_load_skip_enable = 1'b1;
  logic      [5:0] a_set = 6'h0, b_set = 6'h0;
  wire logic       reg_wr, reg_rd, busy, blank;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [5:0] a_code, b_code, lin;
  logic      [7:0] d;
  int              bad_count = 0, comparisons = 0, n;
  dvsrc_ramp_control #(.BLANK_CYC(50), .DWELL_CYC(2)) u_dvsrc_ramp_control (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .unlocked(unlocked),
    .buck_a_set_wr(a_wr), .buck_a_set(a_set), .buck_b_set_wr(b_wr),
    .buck_b_set(b_set), .reg_rdata(reg_rdata), .core_buck_a_code(a_code),
    .core_buck_b_code(b_code), .ramp_busy(busy), .linear_reg_code(lin),
    .monitor_blank(blank));
  dvsrc_host u_dvsrc_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial forever #2 clk = ~clk;
  task chk(input string s, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    u_dvsrc_host.rd(8'h1A, d); chk("ramp", d, 8'h06);
    u_dvsrc_host.rd(8'h1B, d); chk("ldo", d, 8'h33);
    u_dvsrc_host.rd(8'h1C, d); chk("unmapped", d, 8'h00);
    $display("reset values done");
  endtask
  task t_regs;
    u_dvsrc_host.wr(8'h1A, 8'h3F);
    u_dvsrc_host.rd(8'h1A, d); chk("ramp rsvd", d, 8'h07);
    u_dvsrc_host.wr(8'h1B, 8'hFF);
    chk("blank on", {7'h0, blank}, 8'h01);
    u_dvsrc_host.rd(8'h1B, d); chk("locked", d, 8'h33);
    unlocked = 1'b1;
    u_dvsrc_host.wr(8'h1B, 8'hFF);
    u_dvsrc_host.rd(8'h1B, d); chk("ldo rsvd", d, 8'h3F);
    chk("lin", {2'h0, lin}, 8'h3F);
    repeat (46) @(negedge clk);
    chk("blank held", {7'h0, blank}, 8'h01);
    @(negedge clk);
    chk("blank end", {7'h0, blank}, 8'h00);
    unlocked = 1'b0;
    $display("register access done");
  endtask
  task t_trig;
    @(negedge clk) {a_wr, a_set, b_wr, b_set} = {1'b1, 6'h5, 1'b1, 6'h9};
    @(negedge clk) {a_wr, b_wr} = 2'h0;
    repeat (10) @(negedge clk);
    chk("no trig", {2'h0, a_code}, 8'h00);
    u_dvsrc_host.wr(8'h1A, 8'h87);
    for (n = 0; n < 50 && !(a_code === 6'h5 && b_code === 6'h9
         && busy === 1'b0); n++) @(negedge clk);
    chk("a", {2'h0, a_code}, 8'h05);
    chk("b", {2'h0, b_code}, 8'h09);
    chk("idle", {7'h0, busy}, 8'h00);
    chk("fast", {7'h0, n < 10}, 8'h01);
    u_dvsrc_host.rd(8'h1A, d); chk("trig clr", d, 8'h07);
    chk("lin kept", {2'h0, lin}, 8'h3F);
    @(negedge clk) {b_wr, b_set} = {1'b1, 6'hC};
    @(negedge clk) b_wr = 1'b0;
    $display("trigger done");
  endtask
  task t_auto(input logic [2:0] r, input logic [5:0] t, input int lo);
    u_dvsrc_host.wr(8'h1A, {5'h08, r});
    if (t < a_code) light_load_skip_enable = 1'b0;
    @(negedge clk) {a_wr, a_set} = {1'b1, t};
    @(negedge clk) a_wr = 1'b0;
    for (n = 0; n < 1000 && a_code !== t; n++) @(negedge clk);
    chk("auto", {2'h0, a_code}, {2'h0, t});
    chk("dwell", {7'h0, n >= lo}, 8'h01);
    chk("b held", {2'h0, b_code}, 8'h09);
    $display("auto rate %0d done skip %0d", r, light_load_skip_enable);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset;
    t_regs;
    t_trig;
    t_auto(3'h6, 6'h8, 4);
    t_auto(3'h4, 6'h5, 16);
    t_auto(3'h0, 6'h7, 128);
    print_verdict;
  end
  initial begin
    #40000;
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
